// ### sim/csg_tick_src.sv
// Source clock model that hands out one-cycle enable ticks.
`timescale 1ns/1ps
`default_nettype none
module csg_tick_src #(
    parameter int PERIOD = 2
) (
    input wire logic ref_clk,
    input wire logic rst,
    output logic tick
);
    int cnt = 0;
    // The phase counter moves on the falling edge, away from the sampling edge.
    always @(negedge ref_clk) begin
        cnt <= (rst || cnt == PERIOD - 1) ? 0 : cnt + 1;
    end
    // One tick per period, silent while reset is held.
    assign tick = (cnt == PERIOD - 1) && !rst;
endmodule
`default_nettype wire

// ### sim/tb_top.sv
// Testbench for the conversion signal generator control block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import csg_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic tick_a, tick_b, rear_a, rear_b, rear_f, clk_a, clk_b, fp;
    csg_req_t req = '0;
    logic [31:0] rdata;
    logic [19:0] dio_en = '0;
    logic [19:0] dio_dat = '0;
    logic [19:0] drv, drv_en;
    int n_fail = 0;
    int check_count = 0;
    int n_pulse = 0;
    int n_rear = 0;
    int g;
    logic [31:0] v;
    // Clock at 100 MHz.
    always #5 ref_clk = ~ref_clk;
    csg_tick_src #(.PERIOD(2)) i_src_a (.ref_clk(ref_clk), .rst(rst), .tick(tick_a));
    csg_tick_src #(.PERIOD(2)) i_src_b (.ref_clk(ref_clk), .rst(rst), .tick(tick_b));
    csg_ctrl #(.DIO_W(20)) i_dut (.ref_clk(ref_clk), .rst(rst), .src_tick_a(tick_a),
        .src_tick_b(tick_b), .req(req), .rdata(rdata), .dio_out_en(dio_en),
        .dio_out_data(dio_dat), .rear_conv_clock_a_pin(rear_a), .rear_conv_clock_b_pin(rear_b),
        .rear_frame_pulse_pin(rear_f), .dio_drive(drv), .dio_drive_en(drv_en),
        .conv_clock_a(clk_a), .conv_clock_b(clk_b), .frame_pulse(fp));
    // Counts frame pulses on the internal output and on the rear pin.
    always @(posedge ref_clk) begin
        if (fp === 1'b1) n_pulse <= n_pulse + 1;
        if (rear_f === 1'b1) n_rear <= n_rear + 1;
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(negedge ref_clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge ref_clk);
        req <= '0;
    endtask
    // Read data is taken one cycle after the strobe.
    task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
        @(negedge ref_clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(negedge ref_clk);
        req <= '0;
        chk(what, rdata, exp);
    endtask
    // Cycles between two rising edges of a clock or pulse output; zero if none.
    task automatic gap(input int sel, output int n);
        logic prev, cur;
        int r;
        r = 0;
        n = 0;
        prev = 1'b1;
        for (int t = 0; t < 600 && r < 2; t++) begin
            @(negedge ref_clk);
            cur = (sel == 0) ? clk_a : (sel == 1) ? clk_b : fp;
            if (cur === 1'b1 && prev !== 1'b1) r++;
            if (r == 1) n++;
            prev = cur;
        end
    endtask
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Watchdog well beyond the roughly 1500 cycles the tests need.
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        wrap_up();
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        rst <= 1'b0;
        rchk("count reset", CSG_OFS_COUNT, 32'h0);
        rchk("enables reset", CSG_OFS_ENABLES, 32'h0);
        rchk("routing reset", CSG_OFS_ROUTING, 32'h0);
        rchk("unmapped read", 12'h334, 32'h0);
        wr(CSG_OFS_COUNT, 32'hFFFFFFFF);
        rchk("count width", CSG_OFS_COUNT, 32'h0FFFFFFF);
        wr(CSG_OFS_CLK_A_CFG, 32'h1);
        wr(CSG_OFS_CLK_B_CFG, 32'h3);
        wr(CSG_OFS_FRAME_CFG, 32'h2);
        wr(CSG_OFS_ENABLES, 32'h000000FF);
        rchk("enable bits", CSG_OFS_ENABLES, 32'h3);
        gap(0, g); chk("clock a period", g, 4);
        gap(1, g); chk("clock b period", g, 8);
        wr(CSG_OFS_ENABLES, 32'h2);
        gap(0, g); chk("clock a stopped", g, 0);
        wr(CSG_OFS_COUNT, 32'h3);
        wr(CSG_OFS_ENABLES, 32'h1);
        repeat (40) @(negedge ref_clk);
        chk("no start on count", n_pulse, 0);
        wr(CSG_OFS_ENABLES, 32'h101);
        gap(2, g); chk("frame spacing", g, 12);
        repeat (100) @(negedge ref_clk);
        chk("burst length", n_pulse, 3);
        wr(CSG_OFS_ENABLES, 32'h1);
        wr(CSG_OFS_ENABLES, 32'h101);
        repeat (100) @(negedge ref_clk);
        chk("burst rearmed", n_pulse, 6);
        wr(CSG_OFS_ENABLES, 32'h3);
        wr(CSG_OFS_COUNT, 32'h0);
        wr(CSG_OFS_ROUTING, 32'h20);
        wr(CSG_OFS_FRAME_CFG, 32'h20000002);
        wr(CSG_OFS_ENABLES, 32'h103);
        gap(2, g); chk("select b spacing", g, 24);
        n_pulse = 0;
        n_rear = 0;
        repeat (230) @(negedge ref_clk);
        chk("continuous", n_pulse, 10);
        chk("rear frame pin", n_rear, 10);
        wr(CSG_OFS_ENABLES, 32'h3);
        repeat (5) @(negedge ref_clk);
        n_pulse = 0;
        repeat (60) @(negedge ref_clk);
        chk("disabled", n_pulse, 0);
        // Run frame pulses every clock one period so the routes carry them.
        wr(CSG_OFS_FRAME_CFG, 32'h0);
        wr(CSG_OFS_ENABLES, 32'h103);
        dio_dat = 20'hFFFFF;
        for (int c = 0; c < 4; c++) begin
            wr(CSG_OFS_ROUTING, c * 21);
            rchk("routing", CSG_OFS_ROUTING, c * 21);
            for (int k = 0; k < 8; k++) begin
                @(negedge ref_clk);
                chk("rear a", rear_a, (c == 2) ? clk_a : 1'b0);
                chk("rear b", rear_b, (c == 2) ? clk_b : 1'b0);
                chk("rear f", rear_f, (c == 2) ? fp : 1'b0);
                chk("front en", drv_en[4:0], (c == 3) ? 5'h15 : 5'h0);
                if (c == 3) chk("front val", drv[4:0] & 5'h15, {fp, 1'b0, clk_b, 1'b0, clk_a});
            end
        end
        dio_en = 20'h80015;
        dio_dat = 20'h80014;
        @(negedge ref_clk);
        chk("dio enable wins", drv_en, 20'h80015);
        chk("dio data wins", drv & drv_en, 20'h80014);
        // A burst of one pulse stops without waiting out the interval.
        wr(CSG_OFS_ENABLES, 32'h3);
        wr(CSG_OFS_COUNT, 32'h1);
        repeat (5) @(negedge ref_clk);
        n_pulse = 0;
        wr(CSG_OFS_ENABLES, 32'h103);
        repeat (100) @(negedge ref_clk);
        chk("single pulse", n_pulse, 1);
        wrap_up();
    end
endmodule
`default_nettype wire

// ### verilog/csg_ctrl.sv
// Conversion clock and frame trigger generators with output routing.
`timescale 1ns/1ps
`default_nettype none
module csg_ctrl
    import csg_pkg::*;
#(
    parameter int DIO_W = 20
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic src_tick_a,
    input wire logic src_tick_b,
    input wire csg_req_t req,
    output logic [31:0] rdata,
    input wire logic [DIO_W-1:0] dio_out_en,
    input wire logic [DIO_W-1:0] dio_out_data,
    output logic rear_conv_clock_a_pin,
    output logic rear_conv_clock_b_pin,
    output logic rear_frame_pulse_pin,
    output logic [DIO_W-1:0] dio_drive,
    output logic [DIO_W-1:0] dio_drive_en,
    output logic conv_clock_a,
    output logic conv_clock_b,
    output logic frame_pulse
);
    // Refuse widths too narrow for the front lines that the generators drive.
    if (DIO_W <= CSG_DIO_F) begin : g_dio_w_bad
        $error("DIO_W too narrow for the generator front lines");
    end

    csg_state_t s;
    csg_state_t next_s;
    logic [1:0] ra;
    logic [1:0] rb;
    logic [1:0] rf;
    logic assoc_rise;

    // Divider step: returns true on the wrap of a source-tick counter.
    function automatic logic div_wrap(input logic [27:0] cnt, input logic [27:0] div);
        div_wrap = (cnt >= div);
    endfunction

    // Clock level: high while the new count sits in the first half of the period.
    function automatic logic clk_high(input logic [27:0] cnt, input logic [27:0] div);
        clk_high = (cnt <= {1'b0, div[27:1]});
    endfunction

    assign assoc_rise = s.clock_sel ? s.tick_b : s.tick_a;

    // Next-state logic for registers, generators and the frame sequencer.
    always_comb begin
        next_s = s;
        next_s.tick_a = 1'b0;
        next_s.tick_b = 1'b0;
        next_s.pulse = 1'b0;
        // Register writes.
        // register writes for all six offsets
        if (req.wr) begin
            unique case (req.addr)
                CSG_OFS_CLK_A_CFG: next_s.div_a = req.wdata[27:0];
                CSG_OFS_CLK_B_CFG: next_s.div_b = req.wdata[27:0];
                CSG_OFS_FRAME_CFG: begin
                    next_s.interval = req.wdata[27:0];
                    next_s.clock_sel = req.wdata[CSG_BIT_FRAME_SEL];
                end
                CSG_OFS_COUNT: next_s.frame_pulse_count = req.wdata[27:0];
                CSG_OFS_ENABLES: next_s.enables = req.wdata[8:0];
                CSG_OFS_ROUTING: next_s.routing = req.wdata[5:0];
                default: ;
            endcase
        end
        // divide source by divider plus one
        // enable bits gate generators
        // A stopped generator parks its count at the divider, so the first tick
        // after enable wraps and the clock starts on a rising edge with its tick.
        if (!s.enables[CSG_BIT_CLK_A_ON]) begin
            next_s.cnt_a = s.div_a;
            next_s.lvl_a = 1'b0;
        end else if (src_tick_a) begin
            if (div_wrap(s.cnt_a, s.div_a)) begin
                next_s.cnt_a = '0;
                next_s.tick_a = 1'b1;
            end else begin
                next_s.cnt_a = s.cnt_a + 28'h1;
            end
            next_s.lvl_a = clk_high(next_s.cnt_a, s.div_a);
        end
        if (!s.enables[CSG_BIT_CLK_B_ON]) begin
            next_s.cnt_b = s.div_b;
            next_s.lvl_b = 1'b0;
        end else if (src_tick_b) begin
            if (div_wrap(s.cnt_b, s.div_b)) begin
                next_s.cnt_b = '0;
                next_s.tick_b = 1'b1;
            end else begin
                next_s.cnt_b = s.cnt_b + 28'h1;
            end
            next_s.lvl_b = clk_high(next_s.cnt_b, s.div_b);
        end
        // frame sequencer started by enable only
        if (!s.enables[CSG_BIT_FRAME_ON]) begin
            next_s.fsm = CSG_IDLE;
        end else begin
            unique case (s.fsm)
                CSG_IDLE: begin
                    next_s.fsm = CSG_WAIT_EDGE;
                    next_s.emitted = '0;
                end
                // first pulse on next associated edge
                CSG_WAIT_EDGE: if (assoc_rise) begin
                    next_s.pulse = 1'b1;
                    next_s.emitted = 28'h1;
                    next_s.gap = '0;
                    next_s.fsm = (s.frame_pulse_count == 28'h1) ? CSG_DONE : CSG_RUN;
                end
                CSG_RUN: if (assoc_rise) begin
                    if (s.gap >= s.interval) begin
                        next_s.gap = '0;
                        next_s.pulse = 1'b1;
                        next_s.emitted = s.emitted + 28'h1;
                        if (s.frame_pulse_count != '0 &&
                            s.emitted + 28'h1 >= s.frame_pulse_count) begin
                            next_s.fsm = CSG_DONE;
                        end
                    end else begin
                        next_s.gap = s.gap + 28'h1;
                    end
                end
                CSG_DONE: next_s.fsm = CSG_DONE;
            endcase
        end
        // Read data, registered.
        next_s.rdata = '0;
        if (req.rd) begin
            unique case (req.addr)
                CSG_OFS_CLK_A_CFG: next_s.rdata = {4'h0, s.div_a};
                CSG_OFS_CLK_B_CFG: next_s.rdata = {4'h0, s.div_b};
                CSG_OFS_FRAME_CFG: next_s.rdata = {2'h0, s.clock_sel, 1'b0, s.interval};
                CSG_OFS_COUNT: next_s.rdata = {4'h0, s.frame_pulse_count};
                CSG_OFS_ENABLES: next_s.rdata = {23'h0, s.enables};
                CSG_OFS_ROUTING: next_s.rdata = {26'h0, s.routing};
                default: next_s.rdata = '0;
            endcase
        end
        next_s.enables[7:2] = '0;
    end

    // State register with synchronous reset.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s <= '0;
            s.div_a <= CSG_DIV_RESET;
            s.div_b <= CSG_DIV_RESET;
            s.interval <= CSG_DIV_RESET;
            s.fsm <= CSG_IDLE;
        end else begin
            s <= next_s;
        end
    end

    assign ra = s.routing[CSG_ROUTE_A_LO +: 2];
    assign rb = s.routing[CSG_ROUTE_B_LO +: 2];
    assign rf = s.routing[CSG_ROUTE_F_LO +: 2];
    assign rdata = s.rdata;
    assign conv_clock_a = s.lvl_a;
    assign conv_clock_b = s.lvl_b;
    assign frame_pulse = s.pulse;

    // clock two route to rear pin
    // clock one route to rear pin
    assign rear_conv_clock_a_pin = (ra == CSG_ROUTE_REAR) & s.lvl_a;
    assign rear_conv_clock_b_pin = (rb == CSG_ROUTE_REAR) & s.lvl_b;
    assign rear_frame_pulse_pin = (rf == CSG_ROUTE_REAR) & s.pulse;

    // front line needs route and clear DIO enable
    always_comb begin
        dio_drive = dio_out_data & dio_out_en;
        dio_drive_en = dio_out_en;
        if (!dio_out_en[CSG_DIO_A] && ra == CSG_ROUTE_FRONT) begin
            dio_drive[CSG_DIO_A] = s.lvl_a;
            dio_drive_en[CSG_DIO_A] = 1'b1;
        end
        if (!dio_out_en[CSG_DIO_B] && rb == CSG_ROUTE_FRONT) begin
            dio_drive[CSG_DIO_B] = s.lvl_b;
            dio_drive_en[CSG_DIO_B] = 1'b1;
        end
        if (!dio_out_en[CSG_DIO_F] && rf == CSG_ROUTE_FRONT) begin
            dio_drive[CSG_DIO_F] = s.pulse;
            dio_drive_en[CSG_DIO_F] = 1'b1;
        end
    end

    // Assertions.
    rst_count_a: assert property (@(posedge ref_clk) rst |=> s.frame_pulse_count == '0)
        else $error("count not zero after reset");
    no_start_a: assert property (@(posedge ref_clk) disable iff (rst)
        !s.enables[CSG_BIT_FRAME_ON] |=> !frame_pulse)
        else $error("frame pulse while disabled");
    edge_start_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(frame_pulse) |-> $past(assoc_rise))
        else $error("pulse not on associated edge");
    done_quiet_a: assert property (@(posedge ref_clk) disable iff (rst)
        s.fsm == CSG_DONE |=> !frame_pulse)
        else $error("pulse after burst done");
    clk_off_a: assert property (@(posedge ref_clk) disable iff (rst)
        !s.enables[CSG_BIT_CLK_A_ON] |=> !conv_clock_a)
        else $error("clock one runs while off");
    dio_wins_a: assert property (@(posedge ref_clk) disable iff (rst)
        dio_out_en[CSG_DIO_F] |-> dio_drive[CSG_DIO_F] == dio_out_data[CSG_DIO_F])
        else $error("DIO data not dominant");
    front_gen_a: assert property (@(posedge ref_clk) disable iff (rst)
        (ra == CSG_ROUTE_FRONT && !dio_out_en[CSG_DIO_A]) |-> dio_drive_en[CSG_DIO_A]
        && dio_drive[CSG_DIO_A] == conv_clock_a)
        else $error("clock one not on front line");
    rear_off_a: assert property (@(posedge ref_clk) disable iff (rst)
        rf[1] == 1'b0 |-> !rear_frame_pulse_pin && !(rb[1] == 1'b0 && rear_conv_clock_b_pin))
        else $error("rear driver active while off");
endmodule
`default_nettype wire

// ### verilog/csg_pkg.sv
// Package for the conversion signal generator control block.
package csg_pkg;
    localparam logic [11:0] CSG_OFS_FRAME_CFG = 12'h32C;
    localparam logic [11:0] CSG_OFS_CLK_A_CFG = 12'h320;
    localparam logic [11:0] CSG_OFS_CLK_B_CFG = 12'h324;
    localparam logic [11:0] CSG_OFS_COUNT = 12'h330;
    localparam logic [11:0] CSG_OFS_ENABLES = 12'h33C;
    localparam logic [11:0] CSG_OFS_ROUTING = 12'h340;
    localparam int CSG_CNT_W = 28;
    localparam int CSG_BIT_CLK_A_ON = 0;
    localparam int CSG_BIT_CLK_B_ON = 1;
    localparam int CSG_BIT_FRAME_ON = 8;
    localparam int CSG_BIT_FRAME_SEL = 29;
    localparam int CSG_ROUTE_A_LO = 0;
    localparam int CSG_ROUTE_B_LO = 2;
    localparam int CSG_ROUTE_F_LO = 4;
    localparam logic [1:0] CSG_ROUTE_REAR = 2'h2;
    localparam logic [1:0] CSG_ROUTE_FRONT = 2'h3;
    localparam int CSG_DIO_A = 0;
    localparam int CSG_DIO_B = 2;
    localparam int CSG_DIO_F = 4;
    localparam logic [27:0] CSG_DIV_RESET = 28'hFFFFFFF;
    typedef enum logic [1:0] {CSG_IDLE, CSG_WAIT_EDGE, CSG_RUN, CSG_DONE} csg_fsm_t;
    // Register bus request.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } csg_req_t;
    typedef struct packed {
        logic [27:0] div_a;
        logic [27:0] div_b;
        logic [27:0] cnt_a;
        logic [27:0] cnt_b;
        logic tick_a;
        logic tick_b;
        logic lvl_a;
        logic lvl_b;
        logic [27:0] interval;
        logic clock_sel;
        logic [27:0] frame_pulse_count;
        logic [8:0] enables;
        logic [5:0] routing;
        csg_fsm_t fsm;
        logic [27:0] gap;
        logic [27:0] emitted;
        logic pulse;
        logic [31:0] rdata;
    } csg_state_t;
endpackage
